// ===== logic/mdb_pkg.sv
// package: register map, field layout and timing of the module disable bank
package mdb_pkg;

    localparam int          REG_COUNT   = 5;
    localparam int          FLAT_W      = 8 * REG_COUNT;
    localparam int          APB_ADDR_W  = 12;
    localparam logic [11:0] REG_OFF [REG_COUNT] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    localparam logic [7:0]  IMPL_MASK [REG_COUNT] = '{8'hc7, 8'h87, 8'h67, 8'h3f, 8'hf1};
    localparam logic [7:0]  CTRL_RESET  = 8'h00;

    // flat bit positions: register index * 8 + bit
    localparam int          SYSCLK_BIT  = 7;
    localparam int          NVM_BIT     = 2;
    localparam logic [39:0] PERIPH_MASK = 40'hf1_3f_67_87_47;

    localparam int          CLK_PERIOD_PS = 8000;
    localparam int          NVM_WAKE_NS   = 1000;
    localparam int          NVM_WAKE_CYC  = (NVM_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          RESTART_NS    = 32;
    localparam int          RESTART_CYC   = (RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef struct packed {
        logic       sysclk_gate_off;
        logic       voltage_ref_off;
        logic [2:0] rsvd;
        logic       nv_memory_ctrl_off;
        logic       refclk_out_off;
        logic       pin_change_off;
    } mdb_ctrl0_t;

    typedef struct packed {
        logic       num_osc_off;
        logic [3:0] rsvd;
        logic       period_timer_off;
        logic       gated_timer_off;
        logic       basic_timer_off;
    } mdb_ctrl1_t;

    typedef struct packed {
        logic       rsvd_hi;
        logic       dac_off;
        logic       adc_off;
        logic [1:0] rsvd;
        logic       comparator_b_off;
        logic       comparator_a_off;
        logic       zero_cross_off;
    } mdb_ctrl2_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic       pwm_unit_six_off;
        logic       pwm_unit_five_off;
        logic       pwm_unit_four_off;
        logic       pwm_unit_three_off;
        logic       capcomp_b_off;
        logic       capcomp_a_off;
    } mdb_ctrl3_t;

    typedef struct packed {
        logic       serial_b_off;
        logic       serial_a_off;
        logic       sync_port_b_off;
        logic       sync_port_a_off;
        logic [2:0] rsvd;
        logic       wavegen_off;
    } mdb_ctrl4_t;

    typedef struct packed {
        mdb_ctrl4_t c4;
        mdb_ctrl3_t c3;
        mdb_ctrl2_t c2;
        mdb_ctrl1_t c1;
        mdb_ctrl0_t c0;
    } mdb_bank_t;

    typedef struct packed {
        logic access_block;
        logic ctrl_wr_block;
        logic ptr_read_zero;
        logic ready;
    } mdb_nvm_t;

endpackage : mdb_pkg

// ===== logic/mdb_bank.sv
// module disable bank: five control registers on apb and the per-peripheral gating
//
// Summary of operation
// - Every control bit clears to zero on any reset, so all peripherals start enabled.
// - Unimplemented bit positions ignore writes and read back as zero.
// - Bit 6 of the first register shuts down the fixed voltage reference.
// - Bits 0 and 1 of the first register shut down pin-change logic and reference clock out.
// - Bit 7 of the second register shuts down the oscillator; bits 6 to 3 are absent.
// - Bits 2, 1, 0 of the second register shut down the period, gated and basic timers.
// - Third register bits 6, 5, 2, 1, 0 shut down dac, adc, comparators b, a and zero-cross.
// - Fourth register bits 5 to 2 shut down pwm six to three, bits 1 and 0 capcomp b and a.
// - Fifth register bits 7 to 4 shut down serial b, serial a, sync port b and sync port a.
// - Fifth register bit 0 shuts down the wave generator; bits 3 to 1 read zero.
// - Bit 7 of the first register stops the system clock to peripherals that use it.
// - A disabled peripheral has clock and control frozen and is held in reset.
// - A re-enabled peripheral restarts from its reset state.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module mdb_bank
#(
    parameter logic [39:0] SYSCLK_USERS = 40'hf1_3f_67_87_47
)
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [mdb_pkg::APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    output mdb_pkg::mdb_bank_t                  mod_off,
    output logic                                sysclk_gate_off,
    output logic      [mdb_pkg::FLAT_W-1:0]     periph_hold_rst,
    output logic      [mdb_pkg::FLAT_W-1:0]     periph_clk_en,
    output mdb_pkg::mdb_nvm_t                   nvm
);
    import mdb_pkg::*;

    if ((SYSCLK_USERS & ~PERIPH_MASK) != 40'h0)
    begin : g_bad_users
        $error("system clock users must be implemented peripheral bits");
    end

    if (RESTART_CYC < 1 || RESTART_CYC > 7 || NVM_WAKE_CYC > 127)
    begin : g_bad_timing
        $error("restart or wake count does not fit its counter");
    end

    // the address decoder carries a three-bit register index
    if (REG_COUNT > 8 || FLAT_W != 8 * REG_COUNT)
    begin : g_bad_count
        $error("register count does not fit the decoder");
    end

    // bit 3 is hit, bits 2:0 the register index
    function automatic logic [3:0] decode(input logic [APB_ADDR_W-1:0] a);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 0; i < REG_COUNT; i++)
        begin
            if (a == REG_OFF[i])
            begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : decode

    logic [REG_COUNT-1:0][7:0] bank;
    logic [REG_COUNT-1:0][7:0] next_bank;
    logic [31:0]               next_prdata;
    logic [3:0]                dec;
    logic [FLAT_W-1:0]         flat;
    logic [6:0]                nvm_cnt;
    logic [6:0]                next_nvm_cnt;
    logic                      wr_go;

    assign dec    = decode(paddr);
    assign wr_go  = psel && penable && pwrite && dec[3] && pstrb[0];
    assign flat   = bank;

    // zero wait states: read data is fetched in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !dec[3];

    always_comb
    begin
        next_bank = bank;
        if (wr_go)
        begin
            next_bank[dec[2:0]] = pwdata[7:0] & IMPL_MASK[dec[2:0]];
        end
    end

    always_comb
    begin
        next_prdata = prdata;
        if (psel && !penable)
        begin
            next_prdata = 32'h0;
            if (dec[3] && !pwrite)
            begin
                next_prdata = {24'h0, bank[dec[2:0]]};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bank   <= {REG_COUNT{CTRL_RESET}};
            prdata <= 32'h0;
        end
        else
        begin
            bank   <= next_bank;
            prdata <= next_prdata;
        end
    end

    assign mod_off         = mdb_bank_t'(bank);
    assign sysclk_gate_off = flat[SYSCLK_BIT];

    for (genvar i = 0; i < FLAT_W; i++)
    begin : g_bit
        logic [2:0] cnt;
        logic [2:0] next_cnt;

        // reset stays on a few clocked cycles after re-enable so the peripheral's
        // synchronous reset sees running clocks before it is released
        always_comb
        begin
            if (flat[i])
            begin
                next_cnt = 3'(RESTART_CYC);
            end
            else if (cnt != 3'h0)
            begin
                next_cnt = cnt - 3'h1;
            end
            else
            begin
                next_cnt = cnt;
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                cnt <= 3'h0;
            end
            else
            begin
                cnt <= next_cnt;
            end
        end

        assign periph_hold_rst[i] = PERIPH_MASK[i] & (flat[i] | (cnt != 3'h0));
        assign periph_clk_en[i]   = PERIPH_MASK[i] & ~flat[i]
                                    & ~(flat[SYSCLK_BIT] & SYSCLK_USERS[i]);
    end

    always_comb
    begin
        if (flat[NVM_BIT])
        begin
            next_nvm_cnt = 7'(NVM_WAKE_CYC);
        end
        else if (nvm_cnt != 7'h0)
        begin
            next_nvm_cnt = nvm_cnt - 7'h1;
        end
        else
        begin
            next_nvm_cnt = nvm_cnt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_cnt <= 7'h0;
        end
        else
        begin
            nvm_cnt <= next_nvm_cnt;
        end
    end

    // readiness only informs software; the wait itself is its duty
    assign nvm.access_block  = flat[NVM_BIT];
    assign nvm.ctrl_wr_block = flat[NVM_BIT];
    assign nvm.ptr_read_zero = flat[NVM_BIT];
    assign nvm.ready         = !flat[NVM_BIT] && nvm_cnt == 7'h0;

    // checker helper: cycles since the memory bit was last set, saturating;
    // a re-set inside the wake window restarts the count instead of failing
    logic [7:0] nvm_quiet;
    logic [7:0] next_nvm_quiet;

    always_comb
    begin
        if (flat[NVM_BIT])
        begin
            next_nvm_quiet = 8'h00;
        end
        else if (nvm_quiet != 8'hff)
        begin
            next_nvm_quiet = nvm_quiet + 8'h01;
        end
        else
        begin
            next_nvm_quiet = nvm_quiet;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_quiet <= 8'hff;
        end
        else
        begin
            nvm_quiet <= next_nvm_quiet;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    AST_RESET_CLEAR: assert property (!$past(rst_n) |-> bank == 40'h0
                                      && periph_clk_en == PERIPH_MASK)
        else $error("bank not clear after reset");
    AST_UNIMPL_ZERO: assert property ((flat & ~40'hf1_3f_67_87_c7) == 40'h0)
        else $error("unimplemented bit set");
    AST_PRDATA_HIGH: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_UNMAPPED: assert property (psel && penable && !dec[3]
                                   |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_HOLD_IDLE: assert property (((periph_hold_rst | periph_clk_en)
                                     & ~PERIPH_MASK) == 40'h0)
        else $error("unimplemented position drives a peripheral");
    AST_VREF_OFF: assert property (mod_off.c0.voltage_ref_off
                                   |-> periph_hold_rst[6] && !periph_clk_en[6])
        else $error("voltage reference not shut down");
    AST_NVM_BLOCK: assert property ($rose(flat[NVM_BIT]) |-> nvm.access_block
                                    && nvm.ptr_read_zero && !nvm.ready ##1 nvm.ctrl_wr_block)
        else $error("memory controller not blocked");
    AST_NVM_WAKE: assert property (!flat[NVM_BIT]
                                   |-> nvm.ready == (nvm_quiet >= 8'(NVM_WAKE_CYC)))
        else $error("memory controller wake time wrong");
    AST_PIN_REFCLK: assert property ((flat[0] |-> periph_hold_rst[0] && !periph_clk_en[0])
                                     and (flat[1] |-> periph_hold_rst[1] && !periph_clk_en[1]))
        else $error("pin-change or reference clock not shut down");
    AST_OSC_OFF: assert property (mod_off.c1.num_osc_off
                                  |-> periph_hold_rst[15] && !periph_clk_en[15])
        else $error("oscillator not shut down");
    AST_TIMERS: assert property (!flat[SYSCLK_BIT] |-> periph_clk_en[10:8] == ~flat[10:8]
                                 && (flat[10:8] & ~periph_hold_rst[10:8]) == 3'h0)
        else $error("timer gating wrong");
    AST_ANALOG: assert property (!flat[7]
                                 |-> periph_clk_en[23:16] == (~flat[23:16] & 8'h67))
        else $error("analog gating wrong");
    AST_PWM: assert property (!flat[7]
                              |-> periph_clk_en[31:24] == (~flat[31:24] & 8'h3f))
        else $error("pwm or capcomp gating wrong");
    AST_SERIAL: assert property (mod_off.c4.serial_b_off
                                 |-> periph_hold_rst[39] && !periph_clk_en[39])
        else $error("serial unit not shut down");
    AST_SERIAL_REST: assert property ((flat[39:36] & ~periph_hold_rst[39:36]) == 4'h0
                                      && (flat[39:36] & periph_clk_en[39:36]) == 4'h0)
        else $error("serial or sync port not shut down");
    AST_WAVEGEN: assert property (flat[32] |-> periph_hold_rst[32] && flat[35:33] == 3'h0)
        else $error("wave generator bits wrong");
    AST_SYSCLK: assert property (flat[7] |-> (periph_clk_en & SYSCLK_USERS) == 40'h0
                                 && !periph_hold_rst[7])
        else $error("system clock not stopped");
    AST_HOLD_MAP: assert property ((flat & PERIPH_MASK & ~periph_hold_rst) == 40'h0)
        else $error("disabled peripheral not held in reset");
    AST_RESTART: assert property ($fell(flat[6])
                                  |-> periph_hold_rst[6] [*4] ##1 !periph_hold_rst[6])
        else $error("restart reset length wrong");
    AST_CAPCOMP_RESTART: assert property ($fell(flat[24])
                                          |-> periph_hold_rst[24] [*4] ##1 !periph_hold_rst[24])
        else $error("capcomp restart reset length wrong");
    AST_CLKEN_BACK: assert property ($fell(flat[6]) && !flat[SYSCLK_BIT]
                                     |-> periph_clk_en[6] && periph_hold_rst[6])
        else $error("clock not back while restart reset held");
    AST_WRITE_NEXT: assert property (psel && penable && pwrite && pstrb[0]
                                     && paddr == 12'h004
                                     |=> bank[1] == ($past(pwdata[7:0]) & 8'h87))
        else $error("write not applied at next edge");
    AST_WRITE_IGNORED: assert property (psel && penable && pwrite && !pstrb[0]
                                        |=> $stable(bank))
        else $error("write without strobe changed the bank");
    AST_MAPPED_OK: assert property (psel && penable && dec[3] |-> !pslverr)
        else $error("mapped access flagged as error");
    AST_READ_BACK: assert property (psel && penable && !pwrite && paddr == 12'h008
                                    |-> prdata == {24'h0, bank[2]} && !pslverr)
        else $error("read data not current");

endmodule : mdb_bank

// ===== sim/mdb_periph_model.sv
// far-side peripheral model: a counter on the gated clock, cleared while held
`timescale 1ns/1ps

module mdb_periph_model
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       hold_rst,
    input  wire logic       clk_en,
    output logic      [7:0] cnt
);
    // no counting without a clock, so a frozen count shows a stopped clock
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cnt <= 8'h00;
        else if (hold_rst)
            cnt <= 8'h00;
        else if (clk_en)
            cnt <= cnt + 8'h01;
    end
endmodule : mdb_periph_model

// ===== sim/mdb_bank_tb.sv
// self-checking bench for the module disable bank
`timescale 1ns/1ps

module mdb_bank_tb;
    import mdb_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst_n   = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [11:0]       paddr   = 12'h000;
    logic [31:0]       pwdata  = 32'h0;
    logic [3:0]        pstrb   = 4'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    mdb_bank_t         mod_off;
    logic              sysclk_gate_off;
    logic [FLAT_W-1:0] hold;
    logic [FLAT_W-1:0] clk_en;
    mdb_nvm_t          nvm;
    logic [7:0]        cnt;
    logic [7:0]        cnt_seen;
    logic [7:0]        d;
    logic [7:0]        exp_reg [REG_COUNT];
    logic [32:0]       exp_q [$];
    logic [15:0]       lfsr = 16'h68b8;
    int                error_cnt = 0;
    int                samples_checked = 0;

    always #4 clk_sys = ~clk_sys;

    mdb_bank uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mod_off(mod_off), .sysclk_gate_off(sysclk_gate_off),
        .periph_hold_rst(hold), .periph_clk_en(clk_en), .nvm(nvm));

    // watched peripheral: voltage reference, first register bit 6
    mdb_periph_model peer (.clk_sys(clk_sys), .rst_n(rst_n), .hold_rst(hold[6]),
        .clk_en(clk_en[6]), .cnt(cnt));

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // system clock gate stops every peripheral that uses it
    function automatic logic [39:0] en_of(input logic [39:0] r);
        return PERIPH_MASK & ~r & (r[SYSCLK_BIT] ? ~PERIPH_MASK : {40{1'b1}});
    endfunction : en_of

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                       input logic [3:0] s);
        int   n;
        logic err;
        n = 0;
        err = 1'b1;
        for (int i = 0; i < REG_COUNT; i++)
            if (REG_OFF[i] == a)
                err = 1'b0;
        // a write answers only with the error flag
        if (w)
            exp_q.push_back({err, 32'h0});
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= dd;
        pstrb  <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 8)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (pready !== 1'b1)
        begin
            error_cnt++;
            wrap_up();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] dd);
        apb(1'b1, a, dd, 4'h1);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err);
        exp_q.push_back({err, 24'h0, e});
        apb(1'b0, a, 32'h0, 4'h0);
    endtask : rd

    // outputs after the restart hold has run out
    task automatic steady();
        logic [39:0] r;
        r = {exp_reg[4], exp_reg[3], exp_reg[2], exp_reg[1], exp_reg[0]};
        repeat (5) @(posedge clk_sys);
        #1;
        chk("mod_off", r, mod_off);
        chk("hold", PERIPH_MASK & r, hold);
        chk("clk_en", en_of(r), clk_en);
        chk("gate", {39'h0, r[SYSCLK_BIT]}, {39'h0, sysclk_gate_off});
        chk("nvm", {37'h0, {3{r[NVM_BIT]}}}, {37'h0, nvm[3:1]});
    endtask : steady

    always @(posedge clk_sys)
    begin
        if (psel && penable && pready)
        begin
            if (exp_q.size() == 0)
                chk("access queue", 40'h0, 40'h1);
            else if (pwrite)
                chk("write err", {7'h0, exp_q.pop_front()}, {7'h0, pslverr, 32'h0});
            else
                chk("read", {7'h0, exp_q.pop_front()}, {7'h0, pslverr, prdata});
        end
    end

    initial
    begin
        foreach (exp_reg[i]) exp_reg[i] = 8'h00;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        steady();
        for (int i = 0; i < REG_COUNT; i++) rd(REG_OFF[i], 8'h00, 1'b0);
        $display("test reset values done");
        for (int k = 0; k < 3; k++)
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                lfsr = lfsr_next(lfsr);
                d = (k == 0) ? 8'hff : lfsr[7:0];
                wr(REG_OFF[i], {lfsr[15:8], 16'h0, d});
                exp_reg[i] = d & IMPL_MASK[i];
                rd(REG_OFF[i], exp_reg[i], 1'b0);
            end
            steady();
        end
        rd(12'h014, 8'h00, 1'b1);
        wr(12'h014, 32'h000000ff);
        apb(1'b1, REG_OFF[1], 32'h00000000, 4'h0);
        steady();
        $display("test register fields done");
        wr(REG_OFF[0], 32'h00000044);
        exp_reg[0] = 8'h44;
        steady();
        chk("peer off", 40'h0, {32'h0, cnt});
        wr(REG_OFF[0], 32'h00000000);
        exp_reg[0] = 8'h00;
        #1;
        chk("restart", 40'h6, {37'h0, hold[6], clk_en[6], nvm.ready});
        repeat (3) @(posedge clk_sys);
        #1;
        chk("restart", 40'h6, {37'h0, hold[6], clk_en[6], nvm.ready});
        @(posedge clk_sys);
        #1;
        chk("restart", 40'h2, {37'h0, hold[6], clk_en[6], nvm.ready});
        chk("peer fresh", 40'h0, {32'h0, cnt});
        repeat (NVM_WAKE_CYC - 9) @(posedge clk_sys);
        #1;
        chk("nvm wake", 40'h0, {39'h0, nvm.ready});
        repeat (10) @(posedge clk_sys);
        #1;
        chk("nvm wake", 40'h1, {39'h0, nvm.ready});
        chk("peer run", 40'd126, {32'h0, cnt});
        $display("test re-enable done");
        wr(REG_OFF[0], 32'h00000080);
        exp_reg[0] = 8'h80;
        #1;
        cnt_seen = cnt;
        steady();
        chk("peer frozen", {32'h0, cnt_seen}, {32'h0, cnt});
        $display("test clock gate done");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (exp_reg[i]) exp_reg[i] = 8'h00;
        steady();
        rd(REG_OFF[0], 8'h00, 1'b0);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : mdb_bank_tb
